/* i2c_wait_defs.svh */
`ifndef I2C_WAIT_DEFS_SVH
`define I2C_WAIT_DEFS_SVH

// bit positions within a byte transfer, counted in serial clock rises
`define IWC_BIT_BYTE      4'h8
`define IWC_BIT_ACK       4'h9
`define IWC_BIT_FIRST     4'h0

// extension code nibbles and the 10-bit prefix
`define IWC_NIB_LOW       4'h0
`define IWC_NIB_HIGH      4'hF
`define IWC_PREFIX_10B    5'h1E
`define IWC_GCALL_ADDR    7'h00

// shift register value that frees the data line on release
`define IWC_RELEASE_BYTE  8'hFF

// reset values
`define IWC_RST_CORE      '0
`define IWC_RST_CAPTURE   9'h1FF

`endif

/* i2c_wait_pkg.sv */
package i2c_wait_pkg;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'h0,
    ST_ADDR    = 2'h1,
    ST_DATA    = 2'h3,
    ST_STANDBY = 2'h2
  } state_t;

  typedef enum logic [1:0] {
    EXT_NONE     = 2'h0,
    EXT_GCALL    = 2'h1,
    EXT_TEN_AUTH = 2'h2,
    EXT_TEN_READ = 2'h3
  } ext_kind_t;

  typedef struct packed {
    state_t     st;
    logic [3:0] cnt;
    logic       busy_wait;
    logic       irq;
    logic       exc;
    logic       coi;
    logic       trc;
    logic       restart_seen;
    logic       addr_match;
    logic       ext_seen;
    logic       ack_addr;
    ext_kind_t  kind;
    logic [7:0] tx;
    logic [7:0] rx;
    logic       txerr;
    logic       sda_oe;
    logic       scl_oe;
    logic       restart_req;
    logic       stop_req;
    logic       scl_s1;
    logic       scl_s2;
    logic       scl_p;
    logic       sda_s1;
    logic       sda_s2;
    logic       sda_p;
  } core_t;

  typedef struct packed {
    logic [8:0] shift;
  } capture_t;

endpackage

/* link_capture_if.sv */
`timescale 1ns/1ps
interface link_capture_if;
  logic [8:0] shift;
  logic       sda;

  modport capture (
    input  sda,
    output shift
  );

  modport core (
    output sda,
    input  shift
  );
endinterface

/* link_capture.sv */
`timescale 1ns/1ps
`include "i2c_wait_defs.svh"

// samples the data line on every rising serial clock edge
module link_capture (
  input wire logic        serial_clock_line_in,
  input wire logic        rstn_in,
  link_capture_if.capture lnk
);
  import i2c_wait_pkg::*;

  capture_t cap_q;
  capture_t cap_d;

  always_comb begin
    cap_d = cap_q;
    if (!rstn_in) begin
      cap_d.shift = `IWC_RST_CAPTURE;
    end else begin
      cap_d.shift = {cap_q.shift[7:0], lnk.sda};
    end
  end

  always_ff @(posedge serial_clock_line_in) begin
    cap_q <= cap_d;
  end

  assign lnk.shift = cap_q.shift;
endmodule

/* i2c_wait_irq_address_control.sv */
`timescale 1ns/1ps
`include "i2c_wait_defs.svh"

// Notes on behaviour
// - receive wait ends on wait release or FFH write; transmit wait on write
// - master only: start or stop trigger also ends wait, then restart/stop
// - clearing interface enable stops communication and ends the wait
// - leave communication withdraws from transfer, ends wait, frees lines
// - with wakeup control set every release action is ignored
// - data phase interrupt and wait at clock 8 or 9 by wait timing select
// - master address byte: interrupt and wait at ninth clock always
// - slave address match: interrupt and wait at ninth clock, always acked
// - slave receiving extension code interrupts at eighth clock
// - mismatch after restart: interrupt at ninth clock, no wait
// - no match and no extension code: no interrupt, no wait
// - stop condition interrupts only with stop interrupt enable set
// - received address compared with own address; match or extension interrupts
// - transmitted byte compared with captured bus byte; mismatch is error
// - upper nibble 0000 or 1111 sets extension flag, interrupt at eighth
// - 10-bit prefix: nibble match sets extension, seven-bit match sets match
// - after extension code slave stays in transfer until leave communication
// - decode general call and 10-bit prefix with direction
// - wait is signalled by holding the serial clock line low
module i2c_wait_irq_address_control (
  input  wire logic       clk_in,
  input  wire logic       rstn_in,
  input  wire logic       ce_in,
  input  wire logic       serial_clock_line_in,
  input  wire logic       serial_data_line_in,
  input  wire logic       interface_enable_in,
  input  wire logic       master_mode_in,
  input  wire logic       wait_timing_select_in,
  input  wire logic       ack_enable_in,
  input  wire logic       stop_interrupt_enable_in,
  input  wire logic       wakeup_control_in,
  input  wire logic       wait_release_in,
  input  wire logic       start_trigger_in,
  input  wire logic       stop_trigger_in,
  input  wire logic       leave_communication_in,
  input  wire logic       shift_write_in,
  input  wire logic [7:0] shift_wdata_in,
  input  wire logic [7:0] own_slave_address_in,
  output logic      [7:0] serial_shift_register_out,
  output logic            serial_bus_interrupt_out,
  output logic            extension_code_flag_out,
  output logic            address_match_flag_out,
  output logic      [1:0] extension_kind_out,
  output logic            transmit_mode_out,
  output logic            tx_error_out,
  output logic            wait_active_out,
  output logic            restart_request_out,
  output logic            stop_request_out,
  output logic            serial_clock_line_out,
  output logic            serial_clock_line_oe_out,
  output logic            serial_data_line_out,
  output logic            serial_data_line_oe_out
);
  import i2c_wait_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers

  function automatic logic is_ext_code(input logic [7:0] b);
    is_ext_code = (b[7:4] == `IWC_NIB_LOW) || (b[7:4] == `IWC_NIB_HIGH);
  endfunction

  function automatic ext_kind_t ext_kind(input logic [7:0] b);
    ext_kind = EXT_NONE;
    if (b[7:1] == `IWC_GCALL_ADDR && !b[0]) begin
      ext_kind = EXT_GCALL;
    end else if (b[7:3] == `IWC_PREFIX_10B) begin
      ext_kind = b[0] ? EXT_TEN_READ : EXT_TEN_AUTH;
    end
  endfunction

  function automatic logic tx_bit(input logic [7:0] b, input logic [3:0] n);
    tx_bit = b[3'(4'h7 - n)];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // link side capture

  // shifter runs on the serial clock; core reads it only while that
  // clock is low, so the byte is settled when it is looked at
  link_capture_if lnk ();

  assign lnk.sda = serial_data_line_in;

  link_capture u_capture (
    .serial_clock_line_in (serial_clock_line_in),
    .rstn_in              (rstn_in),
    .lnk                  (lnk.capture)
  );

  ////////////////////////////////////////////////////////////////////////////
  // core state

  core_t q;
  core_t d;

  logic       scl_rise;
  logic       scl_fall;
  logic       start_det;
  logic       stop_det;
  logic       release_req;
  logic       tx_active;
  logic       ack_now;
  logic [7:0] byte8;
  logic       match8;
  logic       ext8;

  always_comb begin
    d = q;
    d.irq         = 1'b0;
    d.restart_req = 1'b0;
    d.stop_req    = 1'b0;

    // pin synchronisers
    d.scl_s1 = serial_clock_line_in;
    d.scl_s2 = q.scl_s1;
    d.scl_p  = q.scl_s2;
    d.sda_s1 = serial_data_line_in;
    d.sda_s2 = q.sda_s1;
    d.sda_p  = q.sda_s2;

    scl_rise  = q.scl_s2 & ~q.scl_p;
    scl_fall  = ~q.scl_s2 & q.scl_p;
    start_det = q.scl_s2 & q.scl_p & q.sda_p & ~q.sda_s2;
    stop_det  = q.scl_s2 & q.scl_p & ~q.sda_p & q.sda_s2;

    // captured byte is stable while the clock line is low
    byte8  = lnk.shift[7:0];
    match8 = byte8[7:1] == own_slave_address_in[7:1];
    ext8   = is_ext_code(byte8);

    if (shift_write_in) begin
      d.tx = shift_wdata_in;
    end

    // release actions
    // refused with no wait pending or under wakeup control
    release_req = wait_release_in | shift_write_in
                | (master_mode_in & (start_trigger_in | stop_trigger_in));
    if (q.busy_wait && release_req && !wakeup_control_in) begin
      d.busy_wait = 1'b0;
      if (master_mode_in && start_trigger_in) begin
        d.restart_req = 1'b1;
      end else if (master_mode_in && stop_trigger_in) begin
        d.stop_req = 1'b1;
      end
    end

    if (scl_rise && q.cnt != `IWC_BIT_ACK) begin
      d.cnt = q.cnt + 4'h1;
    end

    ////////////////////////////////////////////////////////////////////////
    // falling edge of the eighth clock

    if (scl_fall && q.cnt == `IWC_BIT_BYTE) begin
      unique case (q.st)
        ST_ADDR: begin
          d.rx = byte8;
          if (master_mode_in) begin
            d.trc      = ~byte8[0];
            d.ack_addr = 1'b0;
          end else begin
            d.trc        = byte8[0];
            d.addr_match = match8;
            d.ext_seen   = ext8;
            d.exc        = ext8;
            d.coi        = match8;
            d.kind       = ext_kind(byte8);
            d.ack_addr   = match8 | (ext8 & ack_enable_in);
            if (ext8) begin
              d.irq = 1'b1;
              if (!wait_timing_select_in) begin
                d.busy_wait = 1'b1;
              end
            end
          end
        end
        ST_DATA: begin
          d.rx = byte8;
          if (q.trc) begin
            d.txerr = byte8 != q.tx;
          end
          if (!wait_timing_select_in) begin
            d.irq       = 1'b1;
            d.busy_wait = 1'b1;
          end
        end
        ST_IDLE, ST_STANDBY: begin
        end
      endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // falling edge of the ninth clock

    if (scl_fall && q.cnt == `IWC_BIT_ACK) begin
      d.cnt = `IWC_BIT_FIRST;
      unique case (q.st)
        ST_ADDR: begin
          if (master_mode_in) begin
            d.irq       = 1'b1;
            d.busy_wait = 1'b1;
            d.st        = ST_DATA;
          end else if (q.ext_seen) begin
            // any extension code: interrupt already raised at clock 8
            if (wait_timing_select_in) begin
              d.busy_wait = 1'b1;
            end
            d.st = ST_DATA;
          end else if (q.addr_match) begin
            d.irq       = 1'b1;
            d.busy_wait = 1'b1;
            d.st        = ST_DATA;
          end else if (q.restart_seen) begin
            d.irq = 1'b1;
            d.st  = ST_STANDBY;
          end else begin
            d.st = ST_STANDBY;
          end
        end
        ST_DATA: begin
          if (wait_timing_select_in) begin
            d.irq       = 1'b1;
            d.busy_wait = 1'b1;
          end
        end
        ST_IDLE, ST_STANDBY: begin
        end
      endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // bus conditions

    // a start while not idle counts as a restart
    if (start_det) begin
      d.restart_seen = q.st != ST_IDLE;
      d.st           = ST_ADDR;
      d.cnt          = `IWC_BIT_FIRST;
      d.busy_wait    = 1'b0;
      d.addr_match   = 1'b0;
      d.ext_seen     = 1'b0;
      d.exc          = 1'b0;
      d.coi          = 1'b0;
      d.kind         = EXT_NONE;
    end

    if (stop_det) begin
      d.st        = ST_IDLE;
      d.cnt       = `IWC_BIT_FIRST;
      d.busy_wait = 1'b0;
      d.exc       = 1'b0;
      d.coi       = 1'b0;
      d.trc       = 1'b0;
      d.irq       = stop_interrupt_enable_in;
    end

    // withdrawal overrides the state, wait and flags set by same-cycle bus events; disable also clears the interrupt
    if (leave_communication_in) begin
      d.st        = ST_STANDBY;
      d.busy_wait = 1'b0;
      d.exc       = 1'b0;
      d.coi       = 1'b0;
      d.ext_seen  = 1'b0;
      d.trc       = 1'b0;
    end

    if (!interface_enable_in) begin
      d.st           = ST_IDLE;
      d.busy_wait    = 1'b0;
      d.cnt          = `IWC_BIT_FIRST;
      d.exc          = 1'b0;
      d.coi          = 1'b0;
      d.trc          = 1'b0;
      d.ext_seen     = 1'b0;
      d.addr_match   = 1'b0;
      d.restart_seen = 1'b0;
      d.irq          = 1'b0;
      d.restart_req  = 1'b0;
      d.stop_req     = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // line drivers, data changes only while the clock line is low, except release on entering idle or standby

    tx_active = (d.st == ST_ADDR && master_mode_in)
              | (d.st == ST_DATA && d.trc);
    ack_now   = (d.st == ST_ADDR) ? d.ack_addr
              : (d.st == ST_DATA && !d.trc && ack_enable_in);
    if (d.st == ST_IDLE || d.st == ST_STANDBY) begin
      d.sda_oe = 1'b0;
    end else if (!q.scl_s2) begin
      if (d.cnt == `IWC_BIT_BYTE) begin
        d.sda_oe = ack_now;
      end else if (tx_active && d.cnt < `IWC_BIT_BYTE) begin
        d.sda_oe = ~tx_bit(d.tx, d.cnt);
      end else begin
        d.sda_oe = 1'b0;
      end
    end
    d.scl_oe = d.busy_wait;
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      q <= `IWC_RST_CORE;
    end else if (ce_in) begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign serial_shift_register_out = q.rx;
  assign serial_bus_interrupt_out  = q.irq;
  assign extension_code_flag_out   = q.exc;
  assign address_match_flag_out    = q.coi;
  assign extension_kind_out        = q.kind;
  assign transmit_mode_out         = q.trc;
  assign tx_error_out              = q.txerr;
  assign wait_active_out           = q.busy_wait;
  assign restart_request_out       = q.restart_req;
  assign stop_request_out          = q.stop_req;
  assign serial_clock_line_out     = 1'b0;
  assign serial_clock_line_oe_out  = q.scl_oe;
  assign serial_data_line_out      = 1'b0;
  assign serial_data_line_oe_out   = q.sda_oe;
endmodule

/* i2c_wait_checker_properties.sv */
`timescale 1ns/1ps
module i2c_wait_checker (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  input wire logic interface_enable_in,
  input wire logic master_mode_in,
  input wire logic wakeup_control_in,
  input wire logic wait_release_in,
  input wire logic start_trigger_in,
  input wire logic leave_communication_in,
  input wire logic serial_bus_interrupt_out,
  input wire logic wait_active_out,
  input wire logic restart_request_out,
  input wire logic serial_clock_line_oe_out,
  input wire logic serial_data_line_oe_out
);
  logic live;
  assign live = ce_in & interface_enable_in & ~leave_communication_in;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  ////////////////////////////////////////
  a_release_ends_wait: assert property (
    live && wait_active_out && wait_release_in && !wakeup_control_in
    |=> !wait_active_out && !serial_clock_line_oe_out)
    else $error("wait kept after release");
  a_wakeup_keeps_wait: assert property (
    live && wait_active_out && wakeup_control_in |=> wait_active_out)
    else $error("wait lost under wakeup control");
  a_disable_frees_lines: assert property (
    ce_in && !interface_enable_in |=> !wait_active_out
    && !serial_clock_line_oe_out && !serial_data_line_oe_out)
    else $error("lines held while disabled");
  a_leave_frees_lines: assert property (
    ce_in && leave_communication_in |=> !wait_active_out
    && !serial_clock_line_oe_out && !serial_data_line_oe_out)
    else $error("lines held after leave");
  a_wait_holds_clock: assert property (
    wait_active_out |-> serial_clock_line_oe_out)
    else $error("wait without clock held low");
  a_start_trigger_restart: assert property (
    live && master_mode_in && wait_active_out && start_trigger_in
    && !wakeup_control_in |=> restart_request_out && !wait_active_out)
    else $error("start trigger not honoured");
  a_restart_has_cause: assert property (
    restart_request_out |-> $past(start_trigger_in) && $past(master_mode_in))
    else $error("restart request without trigger");
  a_irq_one_cycle: assert property (
    serial_bus_interrupt_out |=> !serial_bus_interrupt_out)
    else $error("interrupt longer than one cycle");
endmodule

/* i2c_far_master.sv */
`timescale 1ns/1ps
// far bus master; open-drain lines, pull-ups resolved by the bench
module i2c_far_master (
  input  wire logic scl_line_in,
  input  wire logic sda_line_in,
  output logic      scl_low_out,
  output logic      sda_low_out
);
  logic [8:0] seen;

  initial begin
    seen = '0;
    sda_low_out = 1'b0;
    scl_low_out = 1'b1;
    // one rise during reset primes the capture shifter
    #50 scl_low_out = 1'b0;
  end

  task automatic frame_start();
    #80 sda_low_out = 1'b1;
    #80 scl_low_out = 1'b1;
  endtask

  // n bits from v[8] down; long low phase lets the device set up data
  task automatic bits(input logic [8:0] v, input int n);
    for (int i = 8; i > 8 - n; i--) begin
      #80 sda_low_out = ~v[i];
      #80 scl_low_out = 1'b0;
      wait (scl_line_in === 1'b1);
      #80 seen = {seen[7:0], sda_line_in};
      scl_low_out = 1'b1;
    end
  endtask

  // repeated start from the middle of a frame
  task automatic frame_restart();
    #80 sda_low_out = 1'b0;
    #80 scl_low_out = 1'b0;
    wait (scl_line_in === 1'b1);
    #80 sda_low_out = 1'b1;
    #80 scl_low_out = 1'b1;
  endtask

  task automatic frame_stop();
    #80 sda_low_out = 1'b1;
    #80 scl_low_out = 1'b0;
    wait (scl_line_in === 1'b1);
    #80 sda_low_out = 1'b0;
  endtask
endmodule

/* test_i2c_wait_irq_address_control.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fails++; \
  $display("MISMATCH %0t got %0h exp %0h", $time, g, e); end end

module test_i2c_wait_irq_address_control;
  logic       clk_in, rstn, en, mst, wts, acke, spie, wup;
  logic       rel, stt, stp, sreq, lrel, swr, p_scl, p_sda;
  logic       irq, exc, coi, trc, txe, wact, rreq, scl_oe, sda_oe;
  logic [1:0] kind;
  logic [7:0] wdata, own, rx, d, a;
  logic [7:0] codes [3] = '{8'h00, 8'hF4, 8'hF5};
  int         fails, tests_run, irq_cnt, cycles, c;
  wire        scl_w = ~(scl_oe | p_scl);
  wire        sda_w = ~(sda_oe | p_sda);

  i2c_wait_irq_address_control DUT (
    .clk_in(clk_in), .rstn_in(rstn), .ce_in(1'b1),
    .serial_clock_line_in(scl_w), .serial_data_line_in(sda_w),
    .interface_enable_in(en), .master_mode_in(mst),
    .wait_timing_select_in(wts), .ack_enable_in(acke),
    .stop_interrupt_enable_in(spie), .wakeup_control_in(wup),
    .wait_release_in(rel), .start_trigger_in(stt),
    .stop_trigger_in(stp), .leave_communication_in(lrel),
    .shift_write_in(swr), .shift_wdata_in(wdata),
    .own_slave_address_in(own), .serial_shift_register_out(rx),
    .serial_bus_interrupt_out(irq), .extension_code_flag_out(exc),
    .address_match_flag_out(coi), .extension_kind_out(kind),
    .transmit_mode_out(trc), .tx_error_out(txe), .wait_active_out(wact),
    .restart_request_out(rreq), .stop_request_out(sreq),
    .serial_clock_line_out(), .serial_clock_line_oe_out(scl_oe),
    .serial_data_line_out(), .serial_data_line_oe_out(sda_oe)
  );

  i2c_far_master link (.scl_line_in(scl_w), .sda_line_in(sda_w),
    .scl_low_out(p_scl), .sda_low_out(p_sda));

  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  always @(posedge clk_in) begin
    if (irq === 1'b1) irq_cnt++;
    cycles++;
    if (cycles == 20000) begin
      fails++;
      wrap_up();
    end
  end
  ////////////////////////////////////////
  function automatic int ext_kind(input logic [7:0] b);
    if (b == 8'h00) return 1;
    if (b[7:3] == 5'h1E) return 2 + b[0];
    return 0;
  endfunction

  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
    #2;
  endtask

  task automatic rel_pulse();
    rel = 1'b1;
    step(1);
    rel = 1'b0;
  endtask

  task automatic wr_pulse(input logic [7:0] v);
    wdata = v;
    swr = 1'b1;
    step(1);
    swr = 0;
  endtask

  task automatic xfer(input logic [7:0] b, input int n, input int i,
                      input logic w);
    int k;
    k = irq_cnt;
    link.bits({b, 1'b1}, n);
    step(8);
    `CHK(irq_cnt - k, i)
    `CHK(wact, w)
  endtask

  task automatic wrap_up();
    if (fails == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    {rstn, mst, wts, acke, spie, wup, rel, stt, stp, lrel, swr} = '0;
    en = 1'b1;
    wdata = 8'h00;
    own = 8'h00;
    step(3);
    rstn = 1'b1;
    void'($urandom(32'hB4FB6C96));
    own = {4'(2 + $urandom % 12), 3'($urandom), 1'b0};
    d = 8'($urandom);
    step(4);
    link.frame_start();
    xfer({own[7:1], 1'b0}, 8, 0, 1'b0);
    xfer(8'hFF, 1, 1, 1'b1);
    `CHK(link.seen[0], 1'b0)
    `CHK(coi, 1'b1)
    `CHK(rx, {own[7:1], 1'b0})
    `CHK(scl_w, 1'b0)
    wup = 1'b1;
    rel_pulse();
    `CHK(wact, 1'b1)
    wup = 1'b0;
    step(1);
    rel_pulse();
    `CHK(wact, 1'b0)
    xfer(d, 8, 1, 1'b1);
    `CHK(rx, d)
    acke = 1'b1;
    wr_pulse(8'hFF);
    `CHK(wact, 1'b0)
    xfer(8'hFF, 1, 0, 1'b0);
    `CHK(link.seen[0], 1'b0)
    wts = 1'b1;
    xfer(~d, 8, 0, 1'b0);
    xfer(8'hFF, 1, 1, 1'b1);
    rel_pulse();
    spie = 1'b1;
    c = irq_cnt;
    link.frame_stop();
    step(8);
    `CHK(irq_cnt - c, 1)
    {spie, wts} = '0;
    c = irq_cnt;
    link.frame_start();
    xfer(own ^ 8'h02, 8, 0, 1'b0);
    xfer(8'hFF, 1, 0, 1'b0);
    link.frame_restart();
    xfer(own ^ 8'h02, 8, 0, 1'b0);
    xfer(8'hFF, 1, 1, 1'b0);
    link.frame_stop();
    step(8);
    `CHK(irq_cnt - c, 1)
    own = 8'hF4;
    foreach (codes[k]) begin
      a = codes[k];
      link.frame_start();
      xfer(a, 8, 1, 1'b1);
      `CHK(exc, 1'b1)
      `CHK(coi, a[7:1] == own[7:1])
      `CHK(kind, 2'(ext_kind(a)))
      rel_pulse();
      xfer(8'hFF, 1, 0, 1'b0);
      `CHK(exc, 1'b1)
      lrel = 1'b1;
      step(1);
      lrel = 1'b0;
      `CHK(exc, 1'b0)
      link.frame_stop();
      step(8);
    end
    mst = 1'b1;
    a = {7'($urandom), 1'b0};
    wr_pulse(a);
    link.frame_start();
    xfer(8'hFF, 8, 0, 1'b0);
    `CHK(link.seen[7:0], a)
    xfer(8'hFF, 1, 1, 1'b1);
    `CHK(trc, 1'b1)
    d = 8'($urandom) | 8'h01;
    wr_pulse(d);
    `CHK(wact, 1'b0)
    xfer(d & 8'hFE, 8, 1, 1'b1);
    `CHK(txe, 1'b1)
    `CHK(rx, d & 8'hFE)
    stp = 1'b1;
    step(1);
    stp = 1'b0;
    `CHK(sreq, 1'b1)
    `CHK(wact, 1'b0)
    xfer(8'hFF, 1, 0, 1'b0);
    xfer(d, 8, 1, 1'b1);
    `CHK(txe, 1'b0)
    stt = 1'b1;
    step(1);
    stt = 1'b0;
    `CHK(rreq, 1'b1)
    `CHK(wact, 1'b0)
    en = 1'b0;
    step(2);
    `CHK(sda_oe, 1'b0)
    wrap_up();
  end
endmodule

bind i2c_wait_irq_address_control i2c_wait_checker u_chk (
  .clk_in(clk_in), .rstn_in(rstn_in), .ce_in(ce_in),
  .interface_enable_in(interface_enable_in),
  .master_mode_in(master_mode_in), .wakeup_control_in(wakeup_control_in),
  .wait_release_in(wait_release_in), .start_trigger_in(start_trigger_in),
  .leave_communication_in(leave_communication_in),
  .serial_bus_interrupt_out(serial_bus_interrupt_out),
  .wait_active_out(wait_active_out),
  .restart_request_out(restart_request_out),
  .serial_clock_line_oe_out(serial_clock_line_oe_out),
  .serial_data_line_oe_out(serial_data_line_oe_out)
);
